// file: inc/cqs_pkg.sv
// constants shared by the charge qualification sequencer and its timer
package cqs_pkg;
  // ------------------------------------------------------------
  // clock and time base
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TERM_FILTER_MS = 1;
  localparam int TERM_FILTER_CYCLES = CLK_HZ / 1000 * TERM_FILTER_MS;
  localparam int TMR_W = 26;

  // ------------------------------------------------------------
  // timer periods in ticks
  // ------------------------------------------------------------
  localparam int PRECHG_MIN = 32;
  localparam int ELAPSE_A_HR = 4;
  localparam int ELAPSE_B_HR = 6;
  localparam int ELAPSE_C_HR = 8;
  localparam int FLASH_PERIOD_MS = 1600;
  localparam logic [TMR_W-1:0] PRECHG_TICKS = TMR_W'(PRECHG_MIN * 60 * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] ELAPSE_A_TICKS = TMR_W'(ELAPSE_A_HR * 3600 * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] ELAPSE_B_TICKS = TMR_W'(ELAPSE_B_HR * 3600 * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] ELAPSE_C_TICKS = TMR_W'(ELAPSE_C_HR * 3600 * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] FLASH_HALF_TICKS = TMR_W'(FLASH_PERIOD_MS / 2 / TICK_MS);
  localparam logic [TMR_W-1:0] TIMER_OFF = 26'h0000000;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CFG_W = 6;
  localparam int CFG_PRECOND_EN = 0;
  localparam int CFG_PRECOND_TMR_EN = 1;
  localparam int CFG_ELAPSE_LO = 2;
  localparam int CFG_RECHARGE_EN = 4;
  localparam int CFG_FLASH_TYPE = 5;
  localparam logic [CFG_W-1:0] CONFIG_RESET = 6'h37;
  localparam int STS_STATE_LO = 0;
  localparam int STS_CMP_LO = 4;
  localparam int STS_FAULT = 16;
  localparam int STS_TMR_RUN = 17;

  // ------------------------------------------------------------
  // comparator vector layout
  // ------------------------------------------------------------
  localparam int CMP_N = 12;
  localparam int CMP_UV = 0;
  localparam int CMP_OV = 1;
  localparam int CMP_HEADROOM = 2;
  localparam int CMP_NEAR_BAT = 3;
  localparam int CMP_EN_HIGH = 4;
  localparam int CMP_CURRENT_SET_ENABLE_PIN_HIZ = 5;
  localparam int CMP_BAT_PRESENT = 6;
  localparam int CMP_BELOW_RESTART = 7;
  localparam int CMP_OVER_REG = 8;
  localparam int CMP_BELOW_PRECOND = 9;
  localparam int CMP_AT_REG = 10;
  localparam int CMP_TERM_LOW = 11;

  typedef enum {
    CQS_SHUTDOWN,
    CQS_STANDBY,
    CQS_PRECOND,
    CQS_CONST_CURRENT,
    CQS_CONST_VOLT,
    CQS_COMPLETE,
    CQS_FAULT
  } cqs_state_t;
endpackage

// file: inc/cqs_tmr_if.sv
// carrier between the sequencer and its timer block
interface cqs_tmr_if;
  logic tick;
  logic tmr_clear;
  logic tmr_run;
  logic [cqs_pkg::TMR_W-1:0] tmr_limit;
  logic tmr_expired;
  logic flash_phase;
  modport seq (input tick, input tmr_expired, input flash_phase,
               output tmr_clear, output tmr_run, output tmr_limit);
  modport tmr (output tick, output tmr_expired, output flash_phase,
               input tmr_clear, input tmr_run, input tmr_limit);
endinterface

// file: logic/cqs_timer.sv
// prescaler, charge safety timer and status flash generator
module cqs_timer #(
  parameter int TICK_CYCLES = cqs_pkg::TICK_CYCLES
) (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rst_sync_n,
  // link to the sequencer
  cqs_tmr_if.tmr t
);
  // ------------------------------------------------------------
  // prescaler: one tick per period
  // ------------------------------------------------------------
  logic [31:0] pre_cnt;
  logic [cqs_pkg::TMR_W-1:0] tmr_cnt;
  logic [cqs_pkg::TMR_W-1:0] flash_cnt;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_cnt <= 32'h00000000;
      t.tick <= 1'b0;
    end else if (pre_cnt >= 32'(TICK_CYCLES - 1)) begin
      pre_cnt <= 32'h00000000;
      t.tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 32'h00000001;
      t.tick <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // safety timer counts ticks; a zero limit means disabled
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tmr_cnt <= cqs_pkg::TIMER_OFF;
    end else if (t.tmr_clear) begin
      tmr_cnt <= cqs_pkg::TIMER_OFF;
    end else if (t.tmr_run && t.tick && !t.tmr_expired) begin
      tmr_cnt <= tmr_cnt + 26'h0000001;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      t.tmr_expired <= 1'b0;
    end else if (t.tmr_clear || t.tmr_limit == cqs_pkg::TIMER_OFF) begin
      t.tmr_expired <= 1'b0;
    end else begin
      t.tmr_expired <= (tmr_cnt >= t.tmr_limit);
    end
  end

  // ------------------------------------------------------------
  // free-running half-period toggle for fault flashing
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flash_cnt <= cqs_pkg::TIMER_OFF;
      t.flash_phase <= 1'b0;
    end else if (t.tick) begin
      if (flash_cnt >= cqs_pkg::FLASH_HALF_TICKS - 26'h0000001) begin
        flash_cnt <= cqs_pkg::TIMER_OFF;
        t.flash_phase <= !t.flash_phase;
      end else begin
        flash_cnt <= flash_cnt + 26'h0000001;
      end
    end
  end
endmodule

// file: logic/cqs_sequencer.sv
// charge qualification sequencer with its register slave
//
// Notes on behaviour
// - stay shut down while supply below lockout
// - need supply headroom over battery to operate
// - supply lockout checks run in every state
// - overvoltage forces shutdown until supply falls
// - supply near battery means power down
// - start charge only when enable sense high
// - high impedance programming pin disables charging
// - charge starts once battery below restart level
// - battery over regulation suspends or blocks charge
// - low battery preconditions at tenth current
// - precondition ends above precondition threshold
// - precondition and its timer are optional
// - timer expiry in precondition or constant current faults until removal or repower
// - precondition timer lasts thirty two minutes
// - constant current until regulation level reached
// - constant current entry clears the timer
// - status pin is open drain
// - status pattern follows charge state
// - voltage phase ends on filtered low current
module cqs_sequencer #(
  parameter int TICK_CYCLES = cqs_pkg::TICK_CYCLES,
  parameter int TERM_FILTER_CYCLES = cqs_pkg::TERM_FILTER_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // comparator results, asynchronous
  input wire logic supply_low_lockout,
  input wire logic supply_over_lockout,
  input wire logic supply_headroom_ok,
  input wire logic supply_near_battery,
  input wire logic enable_sense_high,
  input wire logic current_set_enable_pin_hiz,
  input wire logic battery_present,
  input wire logic below_restart_charge_level,
  input wire logic above_regulation_level_hyst,
  input wire logic below_precond_level,
  input wire logic at_regulation_level,
  input wire logic term_current_low,
  // charge control
  output logic pass_enable,
  output logic precond_current_sel,
  output logic constant_current_phase,
  output logic const_volt_phase,
  // open-drain status pin
  output logic status_o,
  output logic status_oe
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ------------------------------------------------------------
  // comparator synchronisers
  // ------------------------------------------------------------
  logic [cqs_pkg::CMP_N-1:0] cmp_raw;
  logic [cqs_pkg::CMP_N-1:0] cmp_meta;
  logic [cqs_pkg::CMP_N-1:0] cmp;

  assign cmp_raw = {term_current_low, at_regulation_level, below_precond_level,
                    above_regulation_level_hyst, below_restart_charge_level,
                    battery_present, current_set_enable_pin_hiz, enable_sense_high,
                    supply_near_battery, supply_headroom_ok, supply_over_lockout,
                    supply_low_lockout};

  genvar gi;
  generate
    for (gi = 0; gi < cqs_pkg::CMP_N; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          cmp_meta[gi] <= 1'b0;
          cmp[gi] <= 1'b0;
        end else begin
          cmp_meta[gi] <= cmp_raw[gi];
          cmp[gi] <= cmp_meta[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // qualification terms
  // ------------------------------------------------------------
  logic supply_ok;
  logic enable_ok;
  logic start_ok;

  // lockout checks are evaluated every cycle regardless of state
  assign supply_ok = !cmp[cqs_pkg::CMP_UV]
                  && cmp[cqs_pkg::CMP_HEADROOM]
                  && !cmp[cqs_pkg::CMP_OV]
                  && !cmp[cqs_pkg::CMP_NEAR_BAT];
  assign enable_ok = cmp[cqs_pkg::CMP_EN_HIGH]
                  && !cmp[cqs_pkg::CMP_CURRENT_SET_ENABLE_PIN_HIZ];
  assign start_ok = enable_ok && cmp[cqs_pkg::CMP_BAT_PRESENT]
                 && cmp[cqs_pkg::CMP_BELOW_RESTART]
                 && !cmp[cqs_pkg::CMP_OVER_REG];

  // ------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------
  logic [cqs_pkg::CFG_W-1:0] config_reg;
  logic precond_en;
  logic precond_tmr_en;
  logic [1:0] elapse_sel;
  logic recharge_en;
  logic flash_type;

  assign precond_en = config_reg[cqs_pkg::CFG_PRECOND_EN];
  assign precond_tmr_en = config_reg[cqs_pkg::CFG_PRECOND_TMR_EN];
  assign elapse_sel = config_reg[cqs_pkg::CFG_ELAPSE_LO +: 2];
  assign recharge_en = config_reg[cqs_pkg::CFG_RECHARGE_EN];
  assign flash_type = config_reg[cqs_pkg::CFG_FLASH_TYPE];

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  cqs_pkg::cqs_state_t state;
  cqs_pkg::cqs_state_t next_state;
  logic term_done;
  logic [31:0] term_cnt;
  cqs_tmr_if tif ();

  // pick the entry state of a fresh cycle
  function automatic cqs_pkg::cqs_state_t start_state(input logic low, input logic pre_en);
    if (low && pre_en) begin
      start_state = cqs_pkg::CQS_PRECOND;
    end else begin
      start_state = cqs_pkg::CQS_CONST_CURRENT;
    end
  endfunction

  // states in which the pass device delivers current
  function automatic logic is_charging(input cqs_pkg::cqs_state_t s);
    is_charging = (s == cqs_pkg::CQS_PRECOND) || (s == cqs_pkg::CQS_CONST_CURRENT)
               || (s == cqs_pkg::CQS_CONST_VOLT);
  endfunction

  function automatic logic [2:0] state_code(input cqs_pkg::cqs_state_t s);
    case (s)
      cqs_pkg::CQS_SHUTDOWN: state_code = 3'h0;
      cqs_pkg::CQS_STANDBY: state_code = 3'h1;
      cqs_pkg::CQS_PRECOND: state_code = 3'h2;
      cqs_pkg::CQS_CONST_CURRENT: state_code = 3'h3;
      cqs_pkg::CQS_CONST_VOLT: state_code = 3'h4;
      cqs_pkg::CQS_COMPLETE: state_code = 3'h5;
      cqs_pkg::CQS_FAULT: state_code = 3'h6;
      default: state_code = 3'h7;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    case (state)
      cqs_pkg::CQS_SHUTDOWN: begin
        if (supply_ok) begin
          next_state = cqs_pkg::CQS_STANDBY;
        end
      end
      cqs_pkg::CQS_STANDBY: begin
        if (start_ok) begin
          next_state = start_state(cmp[cqs_pkg::CMP_BELOW_PRECOND], precond_en);
        end
      end
      cqs_pkg::CQS_PRECOND: begin
        if (tif.tmr_expired) begin
          next_state = cqs_pkg::CQS_FAULT;
        end else if (!cmp[cqs_pkg::CMP_BELOW_PRECOND]) begin
          next_state = cqs_pkg::CQS_CONST_CURRENT;
        end
      end
      cqs_pkg::CQS_CONST_CURRENT: begin
        if (tif.tmr_expired) begin
          next_state = cqs_pkg::CQS_FAULT;
        end else if (cmp[cqs_pkg::CMP_AT_REG]) begin
          next_state = cqs_pkg::CQS_CONST_VOLT;
        end
      end
      cqs_pkg::CQS_CONST_VOLT: begin
        if (term_done || tif.tmr_expired) begin
          next_state = cqs_pkg::CQS_COMPLETE;
        end
      end
      cqs_pkg::CQS_COMPLETE: begin
        if (!cmp[cqs_pkg::CMP_BAT_PRESENT] || !enable_ok) begin
          next_state = cqs_pkg::CQS_STANDBY;
        end else if (recharge_en && start_ok) begin
          next_state = start_state(cmp[cqs_pkg::CMP_BELOW_PRECOND], precond_en);
        end
      end
      cqs_pkg::CQS_FAULT: begin
        // only removal or loss of supply leaves the fault
        if (!cmp[cqs_pkg::CMP_BAT_PRESENT]) begin
          next_state = cqs_pkg::CQS_STANDBY;
        end
      end
      default: begin
        next_state = cqs_pkg::CQS_SHUTDOWN;
      end
    endcase
    // suspend a running cycle on removal, disable or overcharge
    if (is_charging(state) && (!enable_ok || !cmp[cqs_pkg::CMP_BAT_PRESENT]
        || cmp[cqs_pkg::CMP_OVER_REG])) begin
      next_state = cqs_pkg::CQS_STANDBY;
    end
    if (!supply_ok) begin
      next_state = cqs_pkg::CQS_SHUTDOWN;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= cqs_pkg::CQS_SHUTDOWN;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // termination filter: low current must persist the whole window
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      term_cnt <= 32'h00000000;
      term_done <= 1'b0;
    end else if (state != cqs_pkg::CQS_CONST_VOLT || !cmp[cqs_pkg::CMP_TERM_LOW]) begin
      term_cnt <= 32'h00000000;
      term_done <= 1'b0;
    end else if (term_cnt >= 32'(TERM_FILTER_CYCLES - 1)) begin
      term_done <= 1'b1;
    end else begin
      term_cnt <= term_cnt + 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // timer control
  // ------------------------------------------------------------
  logic [cqs_pkg::TMR_W-1:0] elapse_limit;

  always_comb begin
    case (elapse_sel)
      2'h1: elapse_limit = cqs_pkg::ELAPSE_A_TICKS;
      2'h2: elapse_limit = cqs_pkg::ELAPSE_B_TICKS;
      2'h3: elapse_limit = cqs_pkg::ELAPSE_C_TICKS;
      default: elapse_limit = cqs_pkg::TIMER_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tif.tmr_clear <= 1'b1;
      tif.tmr_run <= 1'b0;
      tif.tmr_limit <= cqs_pkg::TIMER_OFF;
    end else begin
      // restart on every state change, except the hand-over into voltage phase
      tif.tmr_clear <= (next_state != state) && (next_state != cqs_pkg::CQS_CONST_VOLT);
      tif.tmr_run <= is_charging(next_state);
      if (next_state == cqs_pkg::CQS_PRECOND) begin
        tif.tmr_limit <= precond_tmr_en ? cqs_pkg::PRECHG_TICKS
                                        : cqs_pkg::TIMER_OFF;
      end else begin
        tif.tmr_limit <= elapse_limit;
      end
    end
  end

  cqs_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_sync_n(rst_sync_n),
    .t(tif.tmr)
  );

  // ------------------------------------------------------------
  // charge control and status pin
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pass_enable <= 1'b0;
      precond_current_sel <= 1'b0;
      constant_current_phase <= 1'b0;
      const_volt_phase <= 1'b0;
      status_o <= 1'b0;
      status_oe <= 1'b0;
    end else begin
      pass_enable <= is_charging(state);
      precond_current_sel <= (state == cqs_pkg::CQS_PRECOND);
      constant_current_phase <= (state == cqs_pkg::CQS_CONST_CURRENT);
      const_volt_phase <= (state == cqs_pkg::CQS_CONST_VOLT);
      status_o <= 1'b0;
      if (state == cqs_pkg::CQS_FAULT) begin
        status_oe <= flash_type && tif.flash_phase;
      end else begin
        status_oe <= is_charging(state);
      end
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] status_word;

  assign status_word = {14'h0000, tif.tmr_run, (state == cqs_pkg::CQS_FAULT),
                        cmp, 1'b0, state_code(state)};

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        if (haddr[7:0] == cqs_pkg::ADDR_CONFIG) begin
          hrdata <= {26'h0000000, config_reg};
        end else if (haddr[7:0] == cqs_pkg::ADDR_STATUS) begin
          hrdata <= status_word;
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      config_reg <= cqs_pkg::CONFIG_RESET;
    end else if (wr_pend && wr_addr == cqs_pkg::ADDR_CONFIG) begin
      config_reg <= hwdata[cqs_pkg::CFG_W-1:0];
    end
  end
endmodule

// file: testbench/cqs_seq_sva.sv
// port checker for the charge qualification sequencer
module cqs_seq_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // comparator results
  input wire logic supply_low_lockout,
  input wire logic supply_over_lockout,
  input wire logic supply_near_battery,
  input wire logic enable_sense_high,
  input wire logic current_set_enable_pin_hiz,
  input wire logic above_regulation_level_hyst,
  input wire logic at_regulation_level,
  // charge control and status
  input wire logic pass_enable,
  input wire logic precond_current_sel,
  input wire logic constant_current_phase,
  input wire logic const_volt_phase,
  input wire logic status_o,
  input wire logic status_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // five samples span two sync stages, the state update and the output flop
  sequence s_held(x);
    x[*5];
  endsequence
  a_status_never_high: assert property (status_o == 1'h0)
    else $error("status pin driven high");
  a_charge_pulls_low: assert property (pass_enable |-> status_oe)
    else $error("status released while charging");
  a_precond_alone: assert property (
    precond_current_sel |-> pass_enable && !constant_current_phase && !const_volt_phase)
    else $error("reduced current outside preconditioning");
  a_uv_shuts_down: assert property (s_held(supply_low_lockout) |=> !pass_enable)
    else $error("charging under lockout");
  a_ov_shuts_down: assert property (s_held(supply_over_lockout) |=> !pass_enable)
    else $error("charging above overvoltage trip");
  a_near_powers_down: assert property (s_held(supply_near_battery) |=> !pass_enable)
    else $error("charging with supply near battery");
  a_hiz_disables: assert property (
    s_held(current_set_enable_pin_hiz) |=> !pass_enable)
    else $error("charging with programming pin open");
  a_overreg_stops: assert property (
    s_held(above_regulation_level_hyst) |=> !pass_enable)
    else $error("charging above regulation");
  a_start_needs_en: assert property ($rose(pass_enable) |-> $past(enable_sense_high, 4))
    else $error("charge started without enable");
  a_cv_after_reg: assert property (
    $rose(const_volt_phase) |-> $past(at_regulation_level, 4))
    else $error("voltage phase before regulation level");
endmodule

bind cqs_sequencer cqs_seq_sva u_sva (
  .clk, .rst_n, .supply_low_lockout, .supply_over_lockout, .supply_near_battery,
  .enable_sense_high, .current_set_enable_pin_hiz, .above_regulation_level_hyst,
  .at_regulation_level, .pass_enable, .precond_current_sel, .constant_current_phase,
  .const_volt_phase, .status_o, .status_oe
);

// file: testbench/cqs_stat_pullup.sv
// status line model: open-drain pin seen by a host input with a pull-up
module cqs_stat_pullup (
  // driver side
  input wire logic status_o,
  input wire logic status_oe,
  // line at the host
  output logic stat_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released line rises to the pull-up, it never keeps the last driven level
  assign stat_line = status_oe ? status_o : 1'h1;
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the charge qualification sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [11:0] cmp;
  logic [31:0] rd;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire pass_enable, precond_current_sel, constant_current_phase, const_volt_phase;
  wire status_o, status_oe, stat_line;
  int err_count;
  int checked;
  int flt[8] = '{0, 1, 2, 3, 4, 5, 6, 8};

  // small tick counts keep the run short
  cqs_sequencer #(.TICK_CYCLES(4), .TERM_FILTER_CYCLES(4)) dut (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .supply_low_lockout(cmp[0]), .supply_over_lockout(cmp[1]),
    .supply_headroom_ok(cmp[2]), .supply_near_battery(cmp[3]),
    .enable_sense_high(cmp[4]), .current_set_enable_pin_hiz(cmp[5]),
    .battery_present(cmp[6]), .below_restart_charge_level(cmp[7]),
    .above_regulation_level_hyst(cmp[8]), .below_precond_level(cmp[9]),
    .at_regulation_level(cmp[10]), .term_current_low(cmp[11]),
    .pass_enable, .precond_current_sel, .constant_current_phase, .const_volt_phase,
    .status_o, .status_oe
  );
  cqs_stat_pullup host (.status_o, .status_oe, .stat_line);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  // state field, charge outputs and the line at the host all follow the state
  task automatic expect_state(input logic [2:0] s);
    logic [3:0] o;
    o = (s == 3'h2) ? 4'hc : (s == 3'h3) ? 4'ha : (s == 3'h4) ? 4'h9 : 4'h0;
    repeat (12) @(posedge clk);
    ahb(1'h0, 32'h4, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, s});
    chk({28'h0, pass_enable, precond_current_sel, constant_current_phase,
         const_volt_phase}, {28'h0, o});
    chk({31'h0, stat_line}, {31'h0, o == 4'h0});
    // okay response, timer-running and fault flags, then the synced comparator copy
    chk({13'h0, hresp, rd[17:4], 4'h0},
        {13'h0, 1'h0, (o != 4'h0), (s == 3'h6), cmp, 4'h0});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    cmp = 12'h001;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    ahb(1'h0, 32'h0, 32'h0);
    chk(rd, 32'h37);
    ahb(1'h1, 32'h4, 32'hffffffff);
    ahb(1'h0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    // timers off so no fault can cut the cycle short
    ahb(1'h1, 32'h0, 32'h11);
    ahb(1'h0, 32'h0, 32'h11);
    chk(rd, 32'h11);
    expect_state(3'h0);
    $display("test 1 done");
    cmp <= 12'h004;
    expect_state(3'h1);
    cmp <= 12'h2d4;
    expect_state(3'h2);
    cmp <= 12'h0d4;
    expect_state(3'h3);
    cmp <= 12'h454;
    expect_state(3'h4);
    cmp <= 12'hc54;
    expect_state(3'h5);
    $display("test 2 done");
    // each upset is applied in mid-charge; the first four lose the supply
    foreach (flt[i]) begin
      cmp <= 12'h2d4;
      expect_state(3'h2);
      cmp <= 12'h2d4 ^ (12'h1 << flt[i]);
      expect_state((i < 4) ? 3'h0 : 3'h1);
    end
    $display("test 3 done");
    ahb(1'h1, 32'h0, 32'h10);
    cmp <= 12'h004;
    expect_state(3'h1);
    cmp <= 12'h2d4;
    expect_state(3'h3);
    $display("test 4 done");
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
